// ### hdl/twb_cfg.svh
// Register map, field positions and phase codes of the two-wire controller.
// Assumes byte addresses on a 32-bit register bus, one register per word.
`ifndef TWB_CFG_SVH
`define TWB_CFG_SVH
`define TWB_OFS_DIV     8'h00
`define TWB_OFS_CTL     8'h04
`define TWB_OFS_DATA    8'h08
`define TWB_OFS_STAT    8'h0C
`define TWB_OFS_OWN     8'h10
`define TWB_REG_RST     8'h00
`define TWB_CTL_DONE    7
`define TWB_CTL_ACK     6
`define TWB_CTL_STA     5
`define TWB_CTL_STO     4
`define TWB_CTL_WCOL    3
`define TWB_CTL_EN      2
`define TWB_CTL_IE      0
`define TWB_STAT_CODE   7:3
`define TWB_STAT_BUSY   2
`define TWB_STAT_MST    1
`define TWB_OWN_ADDR    7:1
`define TWB_OWN_GCE     0
`define TWB_GCALL_ADDR  7'h00
`define TWB_BYTE_BITS   4'h8
`define TWB_PH_SET      2'h0
`define TWB_PH_RISE     2'h1
`define TWB_PH_HIGH     2'h2
`define TWB_PH_FALL     2'h3
`define TWB_RESP_OKAY   2'h0
`define TWB_RESP_SLVERR 2'h2
`endif

// ### hdl/twb_pkg.sv
// Types shared by the two-wire controller and its register bus slave.
// Assumes twb_cfg.svh is on the include path.
`default_nettype none
`include "twb_cfg.svh"
package twb_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_BYTE, ST_HOLD, ST_STOP,
    ST_S_RX, ST_S_ACK, ST_S_TX, ST_S_HOLD
  } twb_fsm_t;

  typedef enum logic [4:0] {
    C_NONE, C_START, C_ADDR_ACK, C_ADDR_NACK, C_TXD_ACK, C_TXD_NACK,
    C_RXD_ACK, C_RXD_NACK, C_ARB_LOST, C_SLA_W, C_SLA_R, C_GCALL,
    C_SRX_DATA, C_STX_ACK, C_STX_NACK
  } twb_code_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } twb_line_t;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } twb_wr_t;

  typedef struct packed {
    logic       aw_ok;
    logic       w_ok;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic       wstrb0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } twb_axs_t;

  typedef struct packed {
    twb_fsm_t   fsm;
    twb_code_t  code;
    logic [1:0] ph;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] div;
    logic [7:0] data;
    logic [7:0] own;
    logic       done;
    logic       ack_en;
    logic       sta;
    logic       sto;
    logic       wcol;
    logic       en;
    logic       ie;
    logic       master;
    logic       busy;
    logic       m_rx;
    logic       m_addr;
    logic       s_addr;
    logic       s_tx;
    logic       s_ack_due;
    logic       nack;
    logic       scl_oe;
    logic       sda_oe;
    logic       scl_q;
    logic       sda_q;
  } twb_state_t;

  function automatic logic twb_hit(input logic [7:0] a);
    twb_hit = (a == `TWB_OFS_DIV) || (a == `TWB_OFS_CTL) ||
              (a == `TWB_OFS_DATA) || (a == `TWB_OFS_STAT) ||
              (a == `TWB_OFS_OWN);
  endfunction : twb_hit
endpackage : twb_pkg
`default_nettype wire

// ### hdl/twb_tick.sv
// Bit-rate divider: one-cycle enable pulse every div+1 clock cycles.
// Assumes a single system clock and synchronous active-low reset.
`default_nettype none
module twb_tick #(
  parameter int W = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         en,
  input  wire logic [W-1:0] div,
  output logic              tick
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         tick_reg;
  logic         tick_next;

  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!en) begin
      cnt_next = '0;
    end else if (cnt_reg >= div) begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule : twb_tick
`default_nettype wire

// ### hdl/twb_axil.sv
// AXI4-Lite slave front end: turns bus transfers into write strobes and
// read lookups. Assumes 8-bit registers in byte lane 0 of each word.
`default_nettype none
`include "twb_cfg.svh"
module twb_axil (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output twb_pkg::twb_wr_t      wr,
  output logic [7:0]            rd_addr,
  input  wire logic [7:0]       rd_data
);
  import twb_pkg::*;
  twb_axs_t r;
  twb_axs_t n;
  logic     go;

  assign s_axi_awready = !r.aw_ok && !r.bvalid;
  assign s_axi_wready  = !r.w_ok && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign go            = r.aw_ok && r.w_ok;
  assign rd_addr       = s_axi_araddr;

  always_comb begin
    n  = r;
    wr = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_ok  = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_ok   = 1'b1;
      n.wdata  = s_axi_wdata[7:0];
      n.wstrb0 = s_axi_wstrb[0];
    end
    if (go) begin
      wr.en    = twb_hit(r.awaddr) && r.wstrb0;
      wr.addr  = r.awaddr;
      wr.data  = r.wdata;
      n.aw_ok  = 1'b0;
      n.w_ok   = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = twb_hit(r.awaddr) ? `TWB_RESP_OKAY : `TWB_RESP_SLVERR;
    end else if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rdata  = twb_hit(s_axi_araddr) ? rd_data : '0;
      n.rresp  = twb_hit(s_axi_araddr) ? `TWB_RESP_OKAY : `TWB_RESP_SLVERR;
    end else if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp  = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rresp  = r.rresp;
  assign s_axi_rdata  = {24'h000000, r.rdata};
endmodule : twb_axil
`default_nettype wire

// ### hdl/twb_ctrl.sv
// Two-wire bus controller: master and addressed-slave engine with an
// AXI4-Lite register file. Assumes open-drain pads resolved outside.
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`default_nettype none
`include "twb_cfg.svh"
module twb_ctrl (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             global_irq_en,
  output logic                  irq,
  input  wire twb_pkg::twb_line_t bus_in,
  output twb_pkg::twb_line_t    bus_out,
  output twb_pkg::twb_line_t    bus_oe
);
  import twb_pkg::*;
  twb_state_t r;
  twb_state_t n;
  twb_wr_t    wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic       tick;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic       rxb;
  logic       gc;
  logic       match;

  twb_axil u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr            (wr),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data)
  );

  twb_tick #(.W(8)) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .en      (r.en),
    .div     (r.div),
    .tick    (tick)
  );

  assign scl_rise   = bus_in.scl && !r.scl_q;
  assign scl_fall   = !bus_in.scl && r.scl_q;
  assign start_seen = bus_in.scl && r.scl_q && r.sda_q && !bus_in.sda;
  assign stop_seen  = bus_in.scl && r.scl_q && !r.sda_q && bus_in.sda;
  assign rxb        = r.m_rx && !r.m_addr;
  assign gc         = r.shift[7:1] == `TWB_GCALL_ADDR && r.own[`TWB_OWN_GCE];
  assign match      = r.shift[7:1] == r.own[`TWB_OWN_ADDR];

  // Register read view; reading has no side effects.
  always_comb begin
    rd_data = '0;
    case (rd_addr)
      `TWB_OFS_DIV:  rd_data = r.div;
      `TWB_OFS_CTL: begin
        rd_data[`TWB_CTL_DONE] = r.done;
        rd_data[`TWB_CTL_ACK]  = r.ack_en;
        rd_data[`TWB_CTL_STA]  = r.sta;
        rd_data[`TWB_CTL_STO]  = r.sto;
        rd_data[`TWB_CTL_WCOL] = r.wcol;
        rd_data[`TWB_CTL_EN]   = r.en;
        rd_data[`TWB_CTL_IE]   = r.ie;
      end
      `TWB_OFS_DATA: rd_data = r.data;
      `TWB_OFS_STAT: begin
        rd_data[`TWB_STAT_CODE] = r.code;
        rd_data[`TWB_STAT_BUSY] = r.busy;
        rd_data[`TWB_STAT_MST]  = r.master;
      end
      `TWB_OFS_OWN:  rd_data = r.own;
      default:       rd_data = '0;
    endcase
  end

  always_comb begin
    n       = r;
    n.scl_q = bus_in.scl;
    n.sda_q = bus_in.sda;
    if (start_seen) begin
      n.busy = 1'b1;
    end else if (stop_seen) begin
      n.busy = 1'b0;
    end
    // Software writes first, so a hardware set later in the cycle wins.
    if (wr.en) begin
      case (wr.addr)
        `TWB_OFS_DIV: n.div = wr.data;
        `TWB_OFS_CTL: begin
          if (wr.data[`TWB_CTL_DONE]) begin
            n.done = 1'b0;
          end
          n.ack_en = wr.data[`TWB_CTL_ACK];
          n.sta    = wr.data[`TWB_CTL_STA];
          n.sto    = wr.data[`TWB_CTL_STO];
          n.en     = wr.data[`TWB_CTL_EN];
          n.ie     = wr.data[`TWB_CTL_IE];
        end
        `TWB_OFS_DATA: begin
          if (r.done) begin
            n.data = wr.data;
            n.wcol = 1'b0;
          end else begin
            n.wcol = 1'b1;
          end
        end
        `TWB_OFS_OWN: n.own = wr.data;
        default: ;
      endcase
    end
    if (!r.en) begin
      n.fsm    = ST_IDLE;
      n.master = 1'b0;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
      n.ph     = `TWB_PH_SET;
    end else if (r.fsm >= ST_S_RX && stop_seen) begin
      n.fsm    = ST_IDLE;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
    end else if (r.fsm >= ST_S_RX && start_seen) begin
      n.fsm    = ST_S_RX;
      n.cnt    = '0;
      n.s_addr = 1'b1;
      n.sda_oe = 1'b0;
    end else begin
      unique case (r.fsm)
        ST_IDLE: begin
          n.scl_oe = 1'b0;
          n.sda_oe = 1'b0;
          if (start_seen && r.ack_en) begin
            n.fsm    = ST_S_RX;
            n.cnt    = '0;
            n.s_addr = 1'b1;
          end else if (r.sta && !r.done && !r.busy && tick) begin
            n.fsm = ST_START;
            n.ph  = `TWB_PH_SET;
          end
        end
        ST_START: if (tick) begin
          unique case (r.ph)
            `TWB_PH_SET: begin
              n.sda_oe = 1'b0;
              n.ph     = `TWB_PH_RISE;
            end
            `TWB_PH_RISE: begin
              n.scl_oe = 1'b0;
              if (bus_in.scl && bus_in.sda) begin
                n.ph = `TWB_PH_HIGH;
              end
            end
            `TWB_PH_HIGH: begin
              n.sda_oe = 1'b1;
              n.master = 1'b1;
              n.ph     = `TWB_PH_FALL;
            end
            `TWB_PH_FALL: begin
              n.scl_oe = 1'b1;
              n.done   = 1'b1;
              n.code   = C_START;
              n.fsm    = ST_HOLD;
              n.m_addr = 1'b1;
              n.m_rx   = 1'b0;
              n.ph     = `TWB_PH_SET;
            end
          endcase
        end
        ST_HOLD: begin
          n.scl_oe = 1'b1;
          if (!r.done) begin
            n.ph  = `TWB_PH_SET;
            n.cnt = '0;
            if (r.sto) begin
              n.fsm = ST_STOP;
            end else if (r.sta) begin
              n.fsm = ST_START;
            end else begin
              n.fsm   = ST_BYTE;
              n.shift = rxb ? '0 : r.data;
            end
          end
        end
        ST_BYTE: if (tick) begin
          unique case (r.ph)
            `TWB_PH_SET: begin
              n.scl_oe = 1'b1;
              if (r.cnt < `TWB_BYTE_BITS) begin
                n.sda_oe = !rxb && !r.shift[7];
              end else begin
                n.sda_oe = rxb && r.ack_en;
              end
              n.ph = `TWB_PH_RISE;
            end
            `TWB_PH_RISE: begin
              n.scl_oe = 1'b0;
              if (bus_in.scl) begin
                n.ph = `TWB_PH_HIGH;
              end
            end
            `TWB_PH_HIGH: begin
              n.ph = `TWB_PH_FALL;
              if (r.cnt == `TWB_BYTE_BITS) begin
                n.nack = bus_in.sda;
              end else if (!rxb && r.shift[7] && !bus_in.sda) begin
                n.fsm    = ST_IDLE;
                n.master = 1'b0;
                n.scl_oe = 1'b0;
                n.sda_oe = 1'b0;
                n.done   = 1'b1;
                n.code   = C_ARB_LOST;
              end else begin
                n.shift = {r.shift[6:0], bus_in.sda};
              end
            end
            `TWB_PH_FALL: begin
              n.scl_oe = 1'b1;
              n.ph     = `TWB_PH_SET;
              n.cnt    = r.cnt + 4'h1;
              if (r.cnt == `TWB_BYTE_BITS) begin
                n.fsm    = ST_HOLD;
                n.done   = 1'b1;
                n.m_addr = 1'b0;
                if (r.m_addr) begin
                  n.m_rx = r.data[0];
                  n.code = r.nack ? C_ADDR_NACK : C_ADDR_ACK;
                end else if (rxb) begin
                  n.data = r.shift;
                  n.code = r.ack_en ? C_RXD_ACK : C_RXD_NACK;
                end else begin
                  n.code = r.nack ? C_TXD_NACK : C_TXD_ACK;
                end
              end
            end
          endcase
        end
        ST_STOP: if (tick) begin
          unique case (r.ph)
            `TWB_PH_SET: begin
              n.scl_oe = 1'b1;
              n.sda_oe = 1'b1;
              n.ph     = `TWB_PH_RISE;
            end
            `TWB_PH_RISE: begin
              n.scl_oe = 1'b0;
              if (bus_in.scl) begin
                n.ph = `TWB_PH_HIGH;
              end
            end
            `TWB_PH_HIGH: begin
              n.sda_oe = 1'b0;
              n.ph     = `TWB_PH_FALL;
            end
            `TWB_PH_FALL: begin
              n.master = 1'b0;
              n.sto    = 1'b0;
              n.fsm    = ST_IDLE;
              n.ph     = `TWB_PH_SET;
            end
          endcase
        end
        ST_S_RX: begin
          n.sda_oe = 1'b0;
          if (scl_rise) begin
            n.shift = {r.shift[6:0], bus_in.sda};
            n.cnt   = r.cnt + 4'h1;
          end else if (scl_fall && r.cnt == `TWB_BYTE_BITS) begin
            n.s_addr    = 1'b0;
            n.s_ack_due = 1'b1;
            n.fsm       = ST_S_HOLD;
            n.scl_oe    = 1'b1;
            n.done      = 1'b1;
            if (!r.s_addr) begin
              n.data = r.shift;
              n.code = C_SRX_DATA;
            end else if (gc) begin
              n.code = C_GCALL;
              n.s_tx = 1'b0;
            end else if (match) begin
              n.code = r.shift[0] ? C_SLA_R : C_SLA_W;
              n.s_tx = r.shift[0];
            end else begin
              n.fsm    = ST_IDLE;
              n.scl_oe = 1'b0;
              n.done   = r.done;
            end
          end
        end
        ST_S_HOLD: begin
          n.scl_oe = 1'b1;
          if (!r.done) begin
            n.scl_oe = 1'b0;
            n.cnt    = '0;
            if (r.s_ack_due) begin
              n.fsm    = ST_S_ACK;
              n.sda_oe = r.ack_en;
            end else if (r.nack) begin
              n.fsm = ST_IDLE;
            end else begin
              n.fsm    = ST_S_TX;
              n.shift  = r.data;
              n.sda_oe = !r.data[7];
            end
          end
        end
        ST_S_ACK: begin
          n.sda_oe = r.ack_en;
          if (scl_fall) begin
            n.cnt   = '0;
            n.shift = r.data;
            if (r.s_tx) begin
              n.fsm    = ST_S_TX;
              n.sda_oe = !r.data[7];
            end else begin
              n.fsm    = ST_S_RX;
              n.sda_oe = 1'b0;
            end
          end
        end
        ST_S_TX: begin
          if (scl_rise && r.cnt == `TWB_BYTE_BITS) begin
            n.nack = bus_in.sda;
          end else if (scl_fall && r.cnt < `TWB_BYTE_BITS) begin
            n.cnt    = r.cnt + 4'h1;
            n.shift  = {r.shift[6:0], 1'b0};
            n.sda_oe = r.cnt < `TWB_BYTE_BITS - 4'h1 && !r.shift[6];
          end else if (scl_fall) begin
            n.s_ack_due = 1'b0;
            n.fsm       = ST_S_HOLD;
            n.scl_oe    = 1'b1;
            n.done      = 1'b1;
            n.code      = r.nack ? C_STX_NACK : C_STX_ACK;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign irq     = r.done && r.ie && global_irq_en;
  assign bus_out = '0;
  assign bus_oe  = '{scl: r.scl_oe, sda: r.sda_oe};
endmodule : twb_ctrl
`default_nettype wire

// ### tb/twb_props.sv
// Port checker for the two-wire controller.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none
module twb_props (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               global_irq_en,
  input wire logic               irq,
  input wire twb_pkg::twb_line_t bus_out,
  input wire twb_pkg::twb_line_t bus_oe
);
  import twb_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_aw_w;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_held;
    irq && bus_oe.scl ##1 irq;
  endsequence
  a_wr_resp: assert property (
    s_aw_w |-> ##[1:3] s_axi_bvalid) else $error("late write response");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp dropped");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata dropped");
  a_rd_resp: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late rdata");
  a_ar_ready: assert property (
    s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
  a_rd_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
  a_open_drain: assert property (
    bus_out == 2'h0) else $error("line driven high");
  a_irq_gate: assert property (
    !global_irq_en |-> !irq) else $error("irq not gated");
  a_scl_stretch: assert property (
    s_held |-> bus_oe.scl) else $error("clock released early");
  a_done_sticky: assert property (
    irq && global_irq_en ##1 global_irq_en |-> irq || $rose(s_axi_bvalid))
    else $error("done flag lost");
endmodule : twb_props
bind twb_ctrl twb_props u_props (.*);
`default_nettype wire

// ### tb/twb_slave.sv
// Slave on the two-wire bus that acknowledges every byte.
// Assumes the bench resolves both lines with pull-ups.
`default_nettype none
module twb_slave (
  input  wire logic scl,
  input  wire logic sda,
  output var logic  sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  initial sda_oe = 1'b0;
  always @(negedge sda) if (scl) n = -1;
  always @(negedge scl) begin
    n++;
    if (n == 8) sda_oe = 1'b1;
    if (n == 9) begin
      sda_oe = 1'b0;
      n = 0;
    end
  end
endmodule : twb_slave
`default_nettype wire

// ### tb/tb_twb_ctrl.sv
// Bench: register checks and a master write of two acked bytes.
// Assumes twb_slave on the wire and twb_cfg.svh on the include path.
`default_nettype none
`include "twb_cfg.svh"
module tb_twb_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import twb_pkg::*;
  logic aclk = 0, aresetn = 0, global_irq_en = 0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic s_axi_rvalid, irq, s_oe, scl_w, sda_w;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  twb_line_t bus_in, bus_out, bus_oe;
  logic [33:0] qr[$];
  logic [1:0] qb[$];
  logic [7:0] qw[$];
  logic [7:0] sh;
  int errors = 0, checks_done = 0, cyc = 0, bn = 0;
  bit stopped = 0;
  assign scl_w = !bus_oe.scl;
  assign sda_w = !(bus_oe.sda | s_oe);
  assign bus_in = '{scl: scl_w, sda: sda_w};
  twb_ctrl dut (.*);
  twb_slave u_slv (.scl(scl_w), .sda(sda_w), .sda_oe(s_oe));
  task chk(input logic [33:0] s, input logic [33:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task summarize;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  always #50 aclk = !aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      summarize();
    end
  end
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, qb.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, qr.pop_front());
  end
  always @(negedge sda_w) if (scl_w) bn = 0;
  always @(posedge sda_w) if (scl_w) stopped = 1;
  always @(posedge scl_w) begin
    bn++;
    if (bn <= 8) sh = {sh[6:0], sda_w};
    if (bn == 9 && qw.size() > 0) begin
      chk(sh, qw.pop_front());
      chk(sda_w, 1'b0);
    end
    if (bn == 9) bn = 0;
  end
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
          input logic [1:0] r);
    @(posedge aclk);
    qb.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge aclk);
    qr.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 0;
  endtask : rd
  task wt(input bit stp);
    int n;
    n = 0;
    while (!(stp ? stopped : irq === 1'b1) && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    chk(n < 3000, 1'b1);
  endtask : wt
  initial begin
    logic [7:0] r;
    void'($urandom(32'h75af973e));
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 5; i++) rd(8'(i * 4), 34'h0);
    rd(8'h14, 34'h200000000);
    r = 8'($urandom);
    wr(`TWB_OFS_DIV, r, 4'h0, 2'h0);
    rd(`TWB_OFS_DIV, 34'h0);
    wr(`TWB_OFS_DIV, r, 4'hF, 2'h0);
    rd(`TWB_OFS_DIV, r);
    wr(8'h14, r, 4'hF, 2'h2);
    wr(`TWB_OFS_DATA, 32'h55, 4'hF, 2'h0);
    rd(`TWB_OFS_CTL, 34'h08);
    wr(`TWB_OFS_DIV, 32'h1, 4'hF, 2'h0);
    global_irq_en <= 1;
    wr(`TWB_OFS_CTL, 32'h25, 4'hF, 2'h0);
    wt(0);
    rd(`TWB_OFS_STAT, 34'h0E);
    @(negedge aclk);
    chk(bus_oe.scl, 1'b1);
    @(posedge aclk) global_irq_en <= 0;
    @(negedge aclk);
    chk(irq, 1'b0);
    @(posedge aclk) global_irq_en <= 1;
    qw.push_back(8'hA0);
    wr(`TWB_OFS_DATA, 32'hA0, 4'hF, 2'h0);
    wr(`TWB_OFS_CTL, 32'h85, 4'hF, 2'h0);
    wt(0);
    rd(`TWB_OFS_STAT, 34'h16);
    r = 8'($urandom);
    qw.push_back(r);
    wr(`TWB_OFS_DATA, r, 4'hF, 2'h0);
    wr(`TWB_OFS_CTL, 32'h85, 4'hF, 2'h0);
    wt(0);
    rd(`TWB_OFS_STAT, 34'h26);
    stopped = 0;
    wr(`TWB_OFS_CTL, 32'h95, 4'hF, 2'h0);
    wt(1);
    rd(`TWB_OFS_CTL, 34'h05);
    wr(`TWB_OFS_CTL, 32'h0, 4'hF, 2'h0);
    @(negedge aclk);
    chk(bus_oe, 2'h0);
    summarize();
  end
endmodule : tb_twb_ctrl
`default_nettype wire
